// file: rtl/cur_frame_consts.svh
`ifndef CUR_FRAME_CONSTS_SVH
`define CUR_FRAME_CONSTS_SVH

// clock and frame timing
`define CLK_PERIOD_NS    5
`define FRAME_PERIOD_MS  10
`define NS_PER_MS        1000000
`define FRAME_CYCLES     (`FRAME_PERIOD_MS * `NS_PER_MS / `CLK_PERIOD_NS)
`define FAULT_TOLERANT_INTERVAL_MS          6500

// payload placement, msb positions (lsb for the checksum) in big-endian bit numbering
`define CRC_LSB          0
`define CRC_W            8
`define CTR_MSB          11
`define CTR_W            4
`define CUR_MSB          23
`define CUR_W            18
`define VCC_MSB          47
`define VCC_W            10
`define TMP_MSB          53
`define TMP_W            9
`define DIAG_MSB         60
`define DIAG_W           5
`define PAYLOAD_W        64
`define BYTE_W           8
`define PAYLOAD_BYTES    8

// transfer function: offset -800 A at 0.05 A per count
`define CUR_OFFSET_CODE  19'sh03E80
`define OVR_LIMIT_CODE   18'h03A98
`define VCC_HIGH_CODE    10'h20D
`define VCC_LOW_CODE     10'h1DB

// communication error history
`define COMM_ERR_LIMIT   4'hA
`define COMM_CLEAN_LIMIT 4'hA
`define CTR_RESET        4'h0

// end-to-end checksum
`define CRC_POLY         8'h1D
`define CRC_INIT         8'hFF
`define DATA_ID_DEFAULT  16'hF3CF

`endif

// file: rtl/cur_frame_pkg.sv
package cur_frame_pkg;

    typedef struct packed {
        logic signed [17:0] current;
        logic        [9:0]  supply;
        logic        [8:0]  temperature;
    } meas_t;

    typedef struct packed {
        logic done;
        logic error;
    } tx_result_t;

    typedef struct packed {
        logic supplyErr;
        logic commErr;
        logic accuracyErr;
        logic generalErr;
        logic overrange;
    } diagnostic_flags_t;

    typedef struct packed {
        logic lostOverrangeDetection;
        logic lostAccuracyCheck;
        logic outsideAccuracy;
    } health_t;

endpackage

// file: rtl/current_sensor_can_frame_builder.sv
// Behaviour
// - checksum, counter, current, supply at fixed bits
// - bit 56 set when current magnitude reaches 750 A
// - bit 57 set on lost detection function
// - bit 58 set outside accuracy limits
// - bit 59 after over ten consecutive errors
// - bit 60 when supply outside 4.75-5.25 V
// - code equals current plus 800 A, per 0.05
// - overrange at 750 A, never within 700
// - overrange reported in protected frame timely
// - current only in protected frames, flagged timely
// - checksum and counter follow protection profile
// - raw values unsigned, big-endian, scaled
`timescale 1ns/1ps
`default_nettype none
`include "cur_frame_consts.svh"

module current_sensor_can_frame_builder
    import cur_frame_pkg::*;
#(
    parameter int unsigned FRAME_CYCLES = `FRAME_CYCLES,
    parameter logic [15:0] DATA_ID      = `DATA_ID_DEFAULT
)
(
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    input  wire meas_t                   meas,
    input  wire health_t                 health,
    input  wire tx_result_t              txResult,
    input  wire logic                    frameReady,
    output logic                         frameValid,
    output logic [`PAYLOAD_W-1:0]        frameData,
    output diagnostic_flags_t            diagFlags
);

    // write a field in big-endian order starting at its msb
    function automatic logic [`PAYLOAD_W-1:0] placeField(
        input logic [`PAYLOAD_W-1:0] p,
        input int                    msbPos,
        input logic [`CUR_W-1:0]     value,
        input int                    width
    );
        logic [`PAYLOAD_W-1:0] q;
        int                    pos;
        q   = p;
        pos = msbPos;
        for (int i = width - 1; i >= 0; i--)
        begin
            q[pos] = value[i];
            if (pos % `BYTE_W == 0)
                pos = pos + 2 * `BYTE_W - 1;
            else
                pos = pos - 1;
        end
        return q;
    endfunction

    function automatic logic [7:0] crcByte(
        input logic [7:0] c,
        input logic [7:0] b
    );
        logic [7:0] r;
        r = c ^ b;
        for (int i = 0; i < `BYTE_W; i++)
        begin
            if (r[7])
                r = {r[6:0], 1'b0} ^ `CRC_POLY;
            else
                r = {r[6:0], 1'b0};
        end
        return r;
    endfunction

    // data id low, data id high, then bytes 1..7
    function automatic logic [7:0] frameCrc(
        input logic [`PAYLOAD_W-1:0] p
    );
        logic [7:0] c;
        c = `CRC_INIT;
        c = crcByte(c, DATA_ID[7:0]);
        c = crcByte(c, DATA_ID[15:8]);
        for (int k = 1; k < `PAYLOAD_BYTES; k++)
            c = crcByte(c, p[k*`BYTE_W +: `BYTE_W]);
        return c;
    endfunction

    // frame period timer
    logic [31:0]            periodCnt_r;
    logic [31:0]            periodCnt_nxt;
    wire                    periodTick;

    // transfer function and magnitude
    wire  signed [18:0]     curSum;
    wire  [`CUR_W-1:0]      curCode;
    wire  [`CUR_W-1:0]      curMag;

    // diagnostics
    wire                    overNow;
    wire                    supplyNow;
    wire                    generalNow;
    wire                    accuracyNow;
    diagnostic_flags_t      diagNow;

    // communication error history
    wire                    txDone;
    wire                    txFail;
    logic [3:0]             errRun_r;
    logic [3:0]             errRun_nxt;
    logic [3:0]             cleanRun_r;
    logic [3:0]             cleanRun_nxt;
    logic                   commErr_r;
    logic                   commErr_nxt;

    // frame assembly
    logic [`CTR_W-1:0]      counter_r;
    logic [`CTR_W-1:0]      counter_nxt;
    wire  [`PAYLOAD_W-1:0]  ctrStage;
    wire  [`PAYLOAD_W-1:0]  curStage;
    wire  [`PAYLOAD_W-1:0]  vccStage;
    wire  [`PAYLOAD_W-1:0]  tmpStage;
    wire  [`PAYLOAD_W-1:0]  rawPayload;
    wire  [`PAYLOAD_W-1:0]  fullPayload;
    wire                    accepted;
    logic                   frameValid_r;
    logic                   frameValid_nxt;
    logic [`PAYLOAD_W-1:0]  frameData_r;
    logic [`PAYLOAD_W-1:0]  frameData_nxt;
    diagnostic_flags_t      diagFlags_r;
    diagnostic_flags_t      diagFlags_nxt;

    assign periodTick    = (periodCnt_r == FRAME_CYCLES - 1);
    assign periodCnt_nxt = periodTick ? 32'h0 : periodCnt_r + 32'h1;

    // code = (I - (-800 A)) / 0.05 A, clamped at zero
    assign curSum  = 19'(meas.current) + `CUR_OFFSET_CODE;
    assign curCode = curSum[18] ? '0 : curSum[`CUR_W-1:0];
    assign curMag  = meas.current[17] ? 18'(-meas.current)
                                      : 18'(meas.current);

    // threshold at 750 A, clear of the 700 A no-report band
    assign overNow   = (curMag >= `OVR_LIMIT_CODE);
    assign supplyNow = (meas.supply > `VCC_HIGH_CODE)
                     || (meas.supply < `VCC_LOW_CODE);
    // either lost self-check makes the general error
    assign generalNow  = health.lostOverrangeDetection
                       || health.lostAccuracyCheck;
    assign accuracyNow = health.outsideAccuracy;

    always_comb
    begin
        diagNow.overrange   = overNow;
        diagNow.generalErr  = generalNow;
        diagNow.accuracyErr = accuracyNow;
        diagNow.commErr     = commErr_r;
        diagNow.supplyErr   = supplyNow;
    end

    assign txDone = txResult.done;
    assign txFail = txResult.done && txResult.error;

    // consecutive error and clean-frame runs, both saturating
    always_comb
    begin
        errRun_nxt   = errRun_r;
        cleanRun_nxt = cleanRun_r;
        commErr_nxt  = commErr_r;
        if (txDone)
        begin
            if (txFail)
            begin
                if (errRun_r <= `COMM_ERR_LIMIT)
                    errRun_nxt = errRun_r + 4'h1;
                cleanRun_nxt = '0;
                if (errRun_r >= `COMM_ERR_LIMIT)
                    commErr_nxt = 1'b1;
            end
            else
            begin
                errRun_nxt = '0;
                if (cleanRun_r < `COMM_CLEAN_LIMIT)
                    cleanRun_nxt = cleanRun_r + 4'h1;
                if (cleanRun_r + 4'h1 >= `COMM_CLEAN_LIMIT)
                    commErr_nxt = 1'b0;
            end
        end
    end

    // field placement in stages, unused bits stay zero
    assign ctrStage   = placeField('0, `CTR_MSB,
                                   18'(counter_r), `CTR_W);
    assign curStage   = placeField(ctrStage, `CUR_MSB,
                                   curCode, `CUR_W);
    assign vccStage   = placeField(curStage, `VCC_MSB,
                                   18'(meas.supply), `VCC_W);
    assign tmpStage   = placeField(vccStage, `TMP_MSB,
                                   18'(meas.temperature), `TMP_W);
    assign rawPayload = placeField(tmpStage, `DIAG_MSB,
                                   18'(diagNow), `DIAG_W);

    // checksum over the finished fields goes into byte 0
    assign fullPayload = {rawPayload[`PAYLOAD_W-1:`CRC_W],
                          frameCrc(rawPayload)};

    assign accepted = frameValid_r && frameReady;

    // handshake and rolling counter
    always_comb
    begin
        frameValid_nxt = frameValid_r;
        counter_nxt    = counter_r;
        if (accepted)
        begin
            frameValid_nxt = 1'b0;
            counter_nxt    = counter_r + 4'h1;
        end
        if (periodTick)
            frameValid_nxt = 1'b1;
    end

    // a pending untaken frame is refreshed, keeping its counter
    always_comb
    begin
        frameData_nxt = frameData_r;
        diagFlags_nxt = diagFlags_r;
        if (periodTick)
        begin
            frameData_nxt = fullPayload;
            diagFlags_nxt = diagNow;
            if (accepted)
                frameData_nxt = {fullPayload[`PAYLOAD_W-1:`CTR_MSB+1],
                                 counter_nxt,
                                 fullPayload[`CTR_MSB-`CTR_W:0]};
        end
    end

    // counter changed after the checksum: recompute on that path
    logic [`PAYLOAD_W-1:0]  latchData;
    assign latchData = (periodTick && accepted)
                     ? {frameData_nxt[`PAYLOAD_W-1:`CRC_W],
                        frameCrc(frameData_nxt)}
                     : frameData_nxt;

    // frame period timer
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            periodCnt_r <= 32'h0;
        else
            periodCnt_r <= periodCnt_nxt;
    end

    // communication error history
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            errRun_r   <= 4'h0;
            cleanRun_r <= 4'h0;
            commErr_r  <= 1'b0;
        end
        else
        begin
            errRun_r   <= errRun_nxt;
            cleanRun_r <= cleanRun_nxt;
            commErr_r  <= commErr_nxt;
        end
    end

    // rolling counter and frame handshake
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            counter_r    <= `CTR_RESET;
            frameValid_r <= 1'b0;
        end
        else
        begin
            counter_r    <= counter_nxt;
            frameValid_r <= frameValid_nxt;
        end
    end

    // held frame and its diagnostic copy
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            frameData_r <= '0;
            diagFlags_r <= '0;
        end
        else
        begin
            frameData_r <= latchData;
            diagFlags_r <= diagFlags_nxt;
        end
    end

    assign frameValid = frameValid_r;
    assign frameData  = frameData_r;
    assign diagFlags  = diagFlags_r;

endmodule // current_sensor_can_frame_builder

`default_nettype wire

// file: sim/bms_partner.sv
`timescale 1ns/1ps
`default_nettype none
module bms_partner
    import cur_frame_pkg::*;
(
    input  wire logic  core_clk,
    input  wire logic  rst,
    input  wire logic  frameValid,
    input  wire logic  stall,
    input  wire logic  failTx,
    output logic       frameReady,
    output tx_result_t txResult
);
    // takes every frame unless stalled
    assign frameReady = !stall;
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            txResult <= '0;
        else
            txResult <= {frameValid && frameReady,
                         frameValid && frameReady && failTx};
    end
endmodule // bms_partner
`default_nettype wire

// file: sim/frame_builder_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module frame_builder_monitor
    import cur_frame_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              rst,
    input wire health_t           health,
    input wire logic              frameReady,
    input wire logic              frameValid,
    input wire logic [63:0]       frameData,
    input wire diagnostic_flags_t diagFlags
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [17:0] cur;
    logic [9:0]  vcc;
    logic [3:0]  ctr_r;
    assign cur = {frameData[23:16], frameData[31:24], frameData[39:38]};
    assign vcc = {frameData[47:40], frameData[55:54]};
    // counter the next fresh frame must carry
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            ctr_r <= 4'h0;
        else if (frameValid && frameReady)
            ctr_r <= frameData[11:8] + 4'h1;
    end
    a_take_drops: assert property (
        frameValid && frameReady |=> !frameValid ||
        frameData[11:8] == $past(frameData[11:8]) + 4'h1)
        else $error("valid after accept");
    a_wait_holds: assert property (
        frameValid && !frameReady |=> frameValid && $stable(frameData[11:8]))
        else $error("untaken frame lost or counter moved");
    a_ctr_step: assert property (
        $rose(frameValid) |-> frameData[11:8] == ctr_r)
        else $error("counter step wrong");
    a_unused_zero: assert property (
        frameValid |-> frameData[15:12] == 4'h0 && frameData[37:32] == 6'h00)
        else $error("unused bits not zero");
    a_diag_copy: assert property (
        frameValid |-> frameData[60:56] == diagFlags)
        else $error("diagnostic field mismatch");
    a_ovr_band: assert property (
        $rose(frameValid) |->
        diagFlags.overrange == (cur >= 18'h07918 || cur <= 18'h003E8))
        else $error("overrange flag wrong");
    a_supply_window: assert property (
        $rose(frameValid) |->
        diagFlags.supplyErr == (vcc > 10'h20D || vcc < 10'h1DB))
        else $error("supply flag wrong");
    a_health_flags: assert property (
        $rose(frameValid) |-> diagFlags.accuracyErr ==
        $past(health.outsideAccuracy) && diagFlags.generalErr ==
        $past(health.lostOverrangeDetection || health.lostAccuracyCheck))
        else $error("health flags wrong");
endmodule // frame_builder_monitor
bind current_sensor_can_frame_builder frame_builder_monitor mon (.core_clk,
    .rst, .health, .frameReady, .frameValid, .frameData, .diagFlags);
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
    import cur_frame_pkg::*;
;
    localparam int FC = 64;
    logic              core_clk = 1'b0;
    logic              rst = 1'b1;
    logic              stall = 1'b0;
    logic              failTx = 1'b0;
    logic              frameReady;
    logic              frameValid;
    logic [63:0]       frameData;
    meas_t             meas = '0;
    health_t           health = '0;
    tx_result_t        txResult;
    diagnostic_flags_t diagFlags;
    logic [3:0]        expCtr = 4'h0;
    int                mismatches = 0;
    int                checksDone = 0;
    int curTab [10] = '{16000, 2000, 0, -2000, -16000,
                        15000, 14999, -15000, -14999, -16200};
    int supTab [4] = '{474, 475, 525, 526};
    always #2.5 core_clk = ~core_clk;
    current_sensor_can_frame_builder #(.FRAME_CYCLES(FC), .DATA_ID(16'hF3CF))
        dut (.core_clk, .rst, .meas, .health, .txResult, .frameReady,
        .frameValid, .frameData, .diagFlags);
    bms_partner partner (.core_clk, .rst, .frameValid, .stall, .failTx,
        .frameReady, .txResult);
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checksDone++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    function automatic logic [7:0] crc(input logic [63:0] f);
        logic [7:0]  c;
        logic [71:0] s;
        c = 8'hFF;
        s = {f[63:8], 8'hF3, 8'hCF};
        for (int k = 0; k < 9; k++)
        begin
            c ^= s[8*k +: 8];
            repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h1D : {c[6:0], 1'b0};
        end
        return c;
    endfunction
    task automatic nextFrame();
        do @(negedge core_clk); while (frameValid !== 1'b0);
        do @(negedge core_clk); while (frameValid !== 1'b1);
    endtask
    task automatic frameTest(input logic signed [17:0] i, input logic [9:0] v,
                             input health_t h, input logic f, input logic c);
        logic [17:0] cd;
        logic [4:0]  d;
        logic [63:0] e;
        @(posedge core_clk);
        meas <= '{i, v, 9'h1A5};
        health <= h;
        failTx <= f;
        nextFrame();
        cd = (i < -18'sd16000) ? 18'h0 : 18'(i + 18'sd16000);
        d = {v > 10'h20D || v < 10'h1DB, c, h.outsideAccuracy,
             h.lostOverrangeDetection || h.lostAccuracyCheck,
             i >= 18'sd15000 || i <= -18'sd15000};
        e = '0;
        e[11:8] = expCtr;
        {e[23:16], e[31:24], e[39:38]} = cd;
        {e[47:40], e[55:54]} = v;
        {e[53:48], e[63:61]} = 9'h1A5;
        e[60:56] = d;
        e[7:0] = crc(e);
        check(frameData, e);
        check(64'(diagFlags), 64'(d));
        expCtr++;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        #100us;
        mismatches++;
        conclude();
    end
    initial
    begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        foreach (curTab[n])
            frameTest(18'(curTab[n]), 10'h1F4, '0, 1'b0,
                      1'b0);
        foreach (supTab[n])
            frameTest(18'sd0, 10'(supTab[n]), '0, 1'b0, 1'b0);
        for (int n = 0; n < 4; n++)
            frameTest(18'sd0, 10'h1F4, 3'(1 << n) | {3{n == 3}}, 1'b0,
                      1'b0);
        $display("test fields done");
        for (int k = 0; k < 23; k++)
            frameTest(18'sd0, 10'h1F4, '0, k < 12,
                      k < 12 ? k >= 11 : k < 22);
        $display("test comm history done");
        @(posedge core_clk);
        stall <= 1'b1;
        nextFrame();
        repeat (FC) @(negedge core_clk);
        check(frameValid, 1'b1);
        check(frameData[11:8], expCtr);
        @(posedge core_clk);
        stall <= 1'b0;
        expCtr++;
        $display("test stall done");
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(negedge core_clk);
        check(frameValid, 1'b0);
        check(frameData, 64'h0);
        check(64'(diagFlags), 64'h0);
        @(posedge core_clk);
        rst <= 1'b0;
        expCtr = 4'h0;
        frameTest(-18'sd16000, 10'h1F4, '0, 1'b0, 1'b0);
        $display("test reset done");
        conclude();
    end
endmodule // tb
`default_nettype wire
